// >>> rtl/config_port_device.sv
// Device end: dual-framing serial slave with shared lock/data output.
`timescale 1ns/1ps
`default_nettype none
module config_port_device (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Serial link
  serial_link_if.device         link,
  // PLL side
  input  wire logic             pllLockIndicator,
  // Register file side
  output logic                  regWrite,
  output logic [4:0]            regWriteAddr,
  output logic [23:0]           regWriteData,
  output logic [5:0]            regReadAddr,
  input  wire logic [23:0]      regReadData,
  output logic                  softReset,
  output logic [1:0]            protocol
);
  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic sclkRise;
  logic enLvl, enRise, enFall;
  logic sdiLvl, lockLvl;

  edge_sync syncSclk (.clk(clk), .rstn(rstn), .async(link.sclk),
    .level(), .rise(sclkRise), .fall());
  edge_sync syncEn (.clk(clk), .rstn(rstn), .async(link.serialPortEnable),
    .level(enLvl), .rise(enRise), .fall(enFall));
  edge_sync syncSdi (.clk(clk), .rstn(rstn), .async(link.sdi),
    .level(sdiLvl), .rise(), .fall());
  edge_sync syncLock (.clk(clk), .rstn(rstn), .async(pllLockIndicator),
    .level(lockLvl), .rise(), .fall());

  // ------------------------------------------------------------------
  // Protocol choice
  // ------------------------------------------------------------------
  // Soft reset clears the frame state but never the chosen protocol,
  // which only a hard reset can release.
  serial_port_pkg::proto_t proto;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      proto <= serial_port_pkg::PROTO_NONE;
    end else if (proto == serial_port_pkg::PROTO_NONE) begin
      if (enRise) begin
        proto <= serial_port_pkg::PROTO_LEGACY;
      end else if (sclkRise) begin
        proto <= serial_port_pkg::PROTO_ADDR;
      end
    end
  end

  logic isLegacy, isAddr;
  assign isLegacy = (proto == serial_port_pkg::PROTO_LEGACY);
  assign isAddr   = (proto == serial_port_pkg::PROTO_ADDR);

  // ------------------------------------------------------------------
  // Frame shifter
  // ------------------------------------------------------------------
  logic [5:0]  edgeCnt;
  logic [31:0] shiftIn;
  logic        readCycle;
  logic [5:0]  next_edgeCnt;
  logic [31:0] next_shiftIn;
  logic        softPulse;

  assign next_edgeCnt = edgeCnt + 6'h01;
  assign next_shiftIn = {shiftIn[30:0], sdiLvl};

  // Legacy frames are bracketed by enable high, addressed frames by enable
  // low, so each framing counts edges only inside its own window.
  // Until the framing is chosen the addressed side listens as well, so the
  // clock rise that picks it is counted as bit 1 of the first frame.
  logic addrSide;
  logic inFrame;
  assign addrSide = isAddr | (proto == serial_port_pkg::PROTO_NONE);
  assign inFrame  = isLegacy ? enLvl : (addrSide & ~enLvl);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      edgeCnt   <= 6'h00;
      shiftIn   <= 32'h0;
      readCycle <= 1'b0;
    end else if (softPulse || (isLegacy && enRise) || enFall) begin
      edgeCnt   <= 6'h00;
      readCycle <= 1'b0;
    end else if (sclkRise && inFrame && edgeCnt < serial_port_pkg::LAST_EDGE)
    begin
      edgeCnt <= next_edgeCnt;
      shiftIn <= next_shiftIn;
      if (isLegacy && next_edgeCnt == serial_port_pkg::LEG_FLAG_EDGE) begin
        readCycle <= sdiLvl;
      end
    end
  end

  // ------------------------------------------------------------------
  // Commit and read-address state
  // ------------------------------------------------------------------
  logic       chipMatch;
  logic [4:0] openReadAddr;
  assign chipMatch = (shiftIn[2:0] == serial_port_pkg::OWN_CHIP_ADDR);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regWrite     <= 1'b0;
      regWriteAddr <= 5'h00;
      regWriteData <= 24'h0;
      openReadAddr <= 5'h00;
      softReset    <= 1'b0;
      softPulse    <= 1'b0;
    end else begin
      regWrite  <= 1'b0;
      softReset <= 1'b0;
      softPulse <= 1'b0;
      if (isLegacy && sclkRise && enLvl && !readCycle &&
          next_edgeCnt == serial_port_pkg::LAST_EDGE) begin
        regWrite     <= 1'b1;
        regWriteAddr <= shiftIn[28:24];
        // Edge 32 carries no data bit: the last one came in on edge 31.
        regWriteData <= shiftIn[23:0];
      end else if (isAddr && enRise &&
                   edgeCnt == serial_port_pkg::LAST_EDGE && chipMatch) begin
        regWrite     <= 1'b1;
        regWriteAddr <= shiftIn[7:3];
        regWriteData <= shiftIn[31:8];
        if (shiftIn[7:3] == serial_port_pkg::READ_ADDR_REG) begin
          openReadAddr <= shiftIn[8 + serial_port_pkg::RD_ADDR_LSB +: 5];
          softReset    <= shiftIn[8 + serial_port_pkg::SOFT_RST_BIT];
          softPulse    <= shiftIn[8 + serial_port_pkg::SOFT_RST_BIT];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Shared output pin
  // ------------------------------------------------------------------
  logic [23:0] outShift;
  logic        dataMode;
  logic        pinValue;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      outShift <= 24'h0;
      dataMode <= 1'b0;
    end else if (softPulse) begin
      dataMode <= 1'b0;
    end else if (isLegacy) begin
      if (sclkRise && enLvl && readCycle) begin
        if (next_edgeCnt == serial_port_pkg::LEG_ADDR_LAST_EDGE + 6'h01) begin
          dataMode <= 1'b1;
          outShift <= regReadData;
        end else if (next_edgeCnt == serial_port_pkg::LAST_EDGE) begin
          dataMode <= 1'b0;
        end else if (dataMode) begin
          outShift <= {outShift[22:0], 1'b0};
        end
      end
      if (!enLvl) begin
        dataMode <= 1'b0;
      end
    end else if (addrSide) begin
      if (enRise) begin
        dataMode <= 1'b0;
      end else if (sclkRise && !enLvl) begin
        if (edgeCnt == 6'h00) begin
          dataMode <= 1'b1;
          outShift <= regReadData;
        end else if (edgeCnt < serial_port_pkg::ADR_DATA_LAST_EDGE) begin
          outShift <= {outShift[22:0], 1'b0};
        end
      end
    end
  end

  // Bit 23 is presented directly at the first data edge, later bits from
  // the shifter, so bit 23 reaches the pin one clk after the rise and later bits two.
  logic firstBit;
  assign firstBit = isLegacy
    ? (next_edgeCnt == serial_port_pkg::LEG_ADDR_LAST_EDGE + 6'h01)
    : (edgeCnt == 6'h00);
  // The legacy address is complete one bit period before it is needed.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regReadAddr <= 6'h00;
    end else begin
      regReadAddr <= isLegacy ? shiftIn[5:0] : {1'b0, openReadAddr};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinValue <= 1'b0;
    end else if (dataMode || (sclkRise && inFrame && firstBit &&
                 (addrSide || readCycle))) begin
      pinValue <= (sclkRise && firstBit) ? regReadData[23] : outShift[23];
    end else begin
      pinValue <= lockLvl;
    end
  end

  assign link.lockdetSerialOutPin   = pinValue;
  assign link.lockdetSerialOutPinOe = 1'b1;
  assign protocol                   = proto;
endmodule : config_port_device
`default_nettype wire

// >>> rtl/serial_port_pkg.sv
// Shared constants and types for the dual-framing serial configuration port.
package serial_port_pkg;

  // ------------------------------------------------------------------
  // Frame layout
  // ------------------------------------------------------------------
  localparam int DATA_W      = 24;
  localparam int LEG_ADDR_W  = 6;
  localparam int REG_ADDR_W  = 5;
  localparam int CHIP_ADDR_W = 3;
  localparam int FRAME_EDGES = 32;
  localparam int CNT_W       = 6;

  // Legacy framing edge numbers (1-based rising edges).
  localparam logic [5:0] LEG_FLAG_EDGE      = 6'h01;
  localparam logic [5:0] LEG_ADDR_LAST_EDGE = 6'h07;
  localparam logic [5:0] LEG_DATA_LAST_EDGE = 6'h1f;
  localparam logic [5:0] LAST_EDGE          = 6'h20;

  // Addressed framing edge numbers.
  localparam logic [5:0] ADR_DATA_LAST_EDGE = 6'h18;

  // Device chip address and register-zero fields.
  localparam logic [2:0] OWN_CHIP_ADDR = 3'h0;
  localparam logic [4:0] READ_ADDR_REG = 5'h00;
  localparam int         RD_ADDR_LSB   = 0;
  localparam int         SOFT_RST_BIT  = 5;

  // Host clock divider: half period of the serial clock in clk cycles.
  localparam int         CLK_PERIOD_NS   = 50;
  localparam int         SCLK_PERIOD_NS  = 400;
  localparam int         SCLK_HALF_CYC   =
    SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [3:0] SCLK_HALF_COUNT = 4'(SCLK_HALF_CYC);

  typedef enum logic [1:0] {
    PROTO_NONE   = 2'b00,
    PROTO_LEGACY = 2'b01,
    PROTO_ADDR   = 2'b10
  } proto_t;

endpackage : serial_port_pkg

// >>> rtl/serial_link_if.sv
// Pin-level link between the host controller and the configuration port.
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
  logic sclk;
  logic serialPortEnable;
  logic sdi;
  logic lockdetSerialOutPin;
  logic lockdetSerialOutPinOe;

  modport device (
    input  sclk,
    input  serialPortEnable,
    input  sdi,
    output lockdetSerialOutPin,
    output lockdetSerialOutPinOe
  );
  modport host (
    output sclk,
    output serialPortEnable,
    output sdi,
    input  lockdetSerialOutPin,
    input  lockdetSerialOutPinOe
  );
endinterface : serial_link_if
`default_nettype wire

// >>> rtl/edge_sync.sv
// Two-flop synchroniser with rise and fall detection on the second stage.
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Asynchronous level in
  input  wire logic async,
  // Synchronised level and edges
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta;
  logic last;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta  <= 1'b0;
      level <= 1'b0;
      last  <= 1'b0;
    end else begin
      meta  <= async;
      level <= meta;
      last  <= level;
    end
  end

  assign rise = level & ~last;
  assign fall = ~level & last;
endmodule : edge_sync
`default_nettype wire

// >>> rtl/config_port_host.sv
// Host end: serial master issuing legacy or addressed frames.
`timescale 1ns/1ps
`default_nettype none
module config_port_host (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Serial link
  serial_link_if.host      link,
  // Command port
  input  wire logic        start,
  input  wire logic        useLegacy,
  input  wire logic        legacyRead,
  input  wire logic [5:0]  frameRegisterAddress,
  input  wire logic [2:0]  frameChipAddress,
  input  wire logic [23:0] frameDataWord,
  output logic             busy,
  output logic             done,
  output logic [23:0]      readData,
  output logic             lockValid,
  output logic             lockState
);
  typedef enum logic [3:0] {
    IDLE = 4'b0001,
    LEAD = 4'b0010,
    RUN  = 4'b0100,
    TAIL = 4'b1000
  } hstate_t;

  hstate_t     state;
  logic [3:0]  div;
  logic        tick;
  logic [5:0]  edges;
  logic [31:0] txShift;
  logic        legacy;
  logic        sclk, en, sdo;
  logic        pinLvl, pinMeta;

  assign tick = (div == serial_port_pkg::SCLK_HALF_COUNT - 4'h1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta <= 1'b0;
      pinLvl  <= 1'b0;
    end else begin
      pinMeta <= link.lockdetSerialOutPin;
      pinLvl  <= pinMeta;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div <= 4'h0;
    end else if (state == IDLE || tick) begin
      div <= 4'h0;
    end else begin
      div <= div + 4'h1;
    end
  end

  // Data changes on the falling serial edge, which this end makes itself.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state    <= IDLE;
      sclk     <= 1'b0;
      en       <= 1'b0;
      sdo      <= 1'b0;
      edges    <= 6'h00;
      txShift  <= 32'h0;
      legacy   <= 1'b0;
      busy     <= 1'b0;
      done     <= 1'b0;
      readData <= 24'h0;
    end else begin
      done <= 1'b0;
      unique case (state)
        IDLE: begin
          if (start) begin
            busy   <= 1'b1;
            legacy <= useLegacy;
            edges  <= 6'h00;
            state  <= LEAD;
            if (useLegacy) begin
              txShift <= {legacyRead, frameRegisterAddress, frameDataWord,
                           1'b0};
              en      <= 1'b1;
              sdo     <= legacyRead;
            end else begin
              txShift <= {frameDataWord, frameRegisterAddress[4:0],
                           frameChipAddress};
              sdo     <= frameDataWord[23];
            end
          end
        end
        LEAD: begin
          if (tick) begin
            state <= RUN;
          end
        end
        RUN: begin
          if (tick) begin
            sclk <= ~sclk;
            if (!sclk) begin
              edges <= edges + 6'h01;
            end else begin
              txShift <= {txShift[30:0], 1'b0};
              sdo     <= txShift[30];
              // The pin lags through two synchronisers, so each falling edge
              // takes the bit of the previous period; the first take is junk
              // and is shifted out by the 24 that follow.
              if (legacy ? (edges > serial_port_pkg::LEG_ADDR_LAST_EDGE)
                         : (edges <= serial_port_pkg::ADR_DATA_LAST_EDGE +
                                      6'h01)) begin
                readData <= {readData[22:0], pinLvl};
              end
              if (edges == serial_port_pkg::LAST_EDGE) begin
                state <= TAIL;
              end
            end
          end
        end
        TAIL: begin
          if (tick) begin
            if (en) begin
              en    <= 1'b0;
              busy  <= 1'b0;
              done  <= 1'b1;
              state <= IDLE;
            end else begin
              en <= 1'b1;
            end
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lockState <= 1'b0;
      lockValid <= 1'b0;
    end else begin
      lockValid <= ~en;
      if (!en) begin
        lockState <= pinLvl;
      end
    end
  end

  // Serial clock comes from the divider at 400 ns, well below 50 MHz.
  assign link.sclk             = sclk;
  assign link.serialPortEnable = en;
  assign link.sdi              = sdo;
endmodule : config_port_host
`default_nettype wire

// >>> bench/serial_link_checker.sv
// Concurrent checks on the serial link between host and device ends.
`timescale 1ns/1ps
`default_nettype none
module serial_link_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Link signals
  input wire logic sclk,
  input wire logic serialPortEnable,
  input wire logic sdi,
  input wire logic lockdetSerialOutPin,
  input wire logic lockdetSerialOutPinOe
);
  // ------------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------------
  logic       sclkQ;
  logic       enQ;
  logic       legacyMode;
  logic       addrMode;
  logic [5:0] edgeCnt;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclkQ <= 1'b0;
      enQ   <= 1'b0;
    end else begin
      sclkQ <= sclk;
      enQ   <= serialPortEnable;
    end
  end

  // Any enable edge starts a fresh count of clock rises.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) edgeCnt <= 6'h00;
    else if (serialPortEnable != enQ) edgeCnt <= 6'h00;
    else if (sclk && !sclkQ) edgeCnt <= edgeCnt + 6'h01;
  end

  // The framing is judged from whichever comes first, an enable rise or a clock rise.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      legacyMode <= 1'b0;
      addrMode   <= 1'b0;
    end else if (!legacyMode && !addrMode) begin
      if (serialPortEnable && !enQ) legacyMode <= 1'b1;
      else if (sclk && !sclkQ) addrMode <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_oe_on;
    lockdetSerialOutPinOe;
  endproperty
  property p_sdi_stable;
    $rose(sclk) |-> $stable(sdi);
  endproperty
  property p_sclk_high;
    $rose(sclk) |=> sclk [*3] ##1 !sclk;
  endproperty
  property p_legacy_count;
    legacyMode && $fell(serialPortEnable) |-> edgeCnt == 6'h20;
  endproperty
  property p_legacy_max;
    legacyMode && serialPortEnable |-> edgeCnt <= 6'h20;
  endproperty
  property p_legacy_lead;
    $rose(serialPortEnable) && !addrMode |-> !sclk ##[1:8] $rose(sclk);
  endproperty
  property p_legacy_idle;
    legacyMode && !serialPortEnable |-> !$rose(sclk);
  endproperty
  property p_addr_count;
    addrMode && $rose(serialPortEnable) |-> edgeCnt == 6'h20;
  endproperty
  property p_addr_no_clk;
    addrMode && serialPortEnable |-> !$rose(sclk);
  endproperty
  property p_addr_en_pulse;
    addrMode && $rose(serialPortEnable) |-> ##[1:40] !serialPortEnable;
  endproperty

  a_oe_on: assert property (p_oe_on)
    else $error("shared pin not driven");
  a_sdi_stable: assert property (p_sdi_stable)
    else $error("data changed at clock rise");
  a_sclk_high: assert property (p_sclk_high)
    else $error("serial clock high time wrong");
  a_legacy_count: assert property (p_legacy_count)
    else $error("legacy frame not 32 clock rises");
  a_legacy_max: assert property (p_legacy_max)
    else $error("legacy frame too long");
  a_legacy_lead: assert property (p_legacy_lead)
    else $error("enable does not lead clock");
  a_legacy_idle: assert property (p_legacy_idle)
    else $error("clock rise outside legacy frame");
  a_addr_count: assert property (p_addr_count)
    else $error("enable rose before 32 clock rises");
  a_addr_no_clk: assert property (p_addr_no_clk)
    else $error("clock rise while enable high");
  a_addr_en_pulse: assert property (p_addr_en_pulse)
    else $error("enable strobe too long");

  c_legacy: cover property (legacyMode && $fell(serialPortEnable));
  c_addr: cover property (addrMode && $rose(serialPortEnable));
  c_readback: cover property (addrMode && $changed(lockdetSerialOutPin));
endmodule : serial_link_checker
`default_nettype wire

// >>> bench/dual_protocol_serial_slave_port_tb.sv
// Testbench joining host and device ends over the serial link.
`timescale 1ns/1ps
`default_nettype none
module dual_protocol_serial_slave_port_tb;
  // Arbitrary identity value returned from register zero.
  localparam logic [23:0] CHIP_ID = 24'h5a5a01;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        pllLock = 1'b1;
  logic        start = 1'b0;
  logic        useLegacy = 1'b1;
  logic        legacyRead = 1'b0;
  logic [5:0]  frameRegisterAddress = 6'h00;
  logic [2:0]  frameChipAddress = 3'h0;
  logic [23:0] frameDataWord = 24'h000000;
  logic        busy, done, lockValid, lockState;
  logic [23:0] readData, regWriteData, regReadData;
  logic        regWrite, softReset;
  logic [4:0]  regWriteAddr;
  logic [5:0]  regReadAddr;
  logic [1:0]  protocol;
  logic [23:0] regs [32];
  int          nFail = 0, numChecks = 0, nWr = 0, nSoft = 0;

  serial_link_if link ();
  always #25 clk = ~clk;
  assign regReadData = (regReadAddr[4:0] == 5'h00) ? CHIP_ID
                                                   : regs[regReadAddr[4:0]];
  always @(posedge clk) begin
    if (regWrite === 1'b1) begin
      regs[regWriteAddr] <= regWriteData;
      nWr <= nWr + 1;
    end
    if (softReset === 1'b1) nSoft <= nSoft + 1;
  end

  config_port_device u_config_port_device (
    .clk(clk), .rstn(rstn), .link(link), .pllLockIndicator(pllLock),
    .regWrite(regWrite), .regWriteAddr(regWriteAddr),
    .regWriteData(regWriteData), .regReadAddr(regReadAddr),
    .regReadData(regReadData), .softReset(softReset), .protocol(protocol));
  config_port_host u_config_port_host (
    .clk(clk), .rstn(rstn), .link(link), .start(start),
    .useLegacy(useLegacy), .legacyRead(legacyRead),
    .frameRegisterAddress(frameRegisterAddress),
    .frameChipAddress(frameChipAddress), .frameDataWord(frameDataWord),
    .busy(busy), .done(done), .readData(readData),
    .lockValid(lockValid), .lockState(lockState));
  serial_link_checker u_serial_link_checker (
    .clk(clk), .rstn(rstn), .sclk(link.sclk),
    .serialPortEnable(link.serialPortEnable), .sdi(link.sdi),
    .lockdetSerialOutPin(link.lockdetSerialOutPin),
    .lockdetSerialOutPinOe(link.lockdetSerialOutPinOe));

  task automatic check(input string what, input logic [31:0] seen, exp);
    numChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic hard_reset;
    rstn = 1'b0;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
  endtask : hard_reset

  // One whole frame; a missing done counts as a mismatch.
  task automatic frame(input logic leg, rd, input logic [5:0] a,
                       input logic [2:0] c, input logic [23:0] d);
    int i;
    @(negedge clk);
    useLegacy = leg;
    legacyRead = rd;
    frameRegisterAddress = a;
    frameChipAddress = c;
    frameDataWord = d;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    for (i = 0; i < 800 && done !== 1'b1; i++) @(negedge clk);
    if (i == 800) check("done", 32'h0, 32'h1);
    repeat (10) @(negedge clk);
  endtask : frame

  initial begin
    hard_reset();
    check("proto", 32'(protocol), 32'(serial_port_pkg::PROTO_NONE));
    frame(1'b1, 1'b0, 6'h05, 3'h0, 24'habcdef);
    check("proto", 32'(protocol), 32'(serial_port_pkg::PROTO_LEGACY));
    check("writes", nWr, 32'h1);
    check("wr addr", 32'(regWriteAddr), 32'h05);
    check("wr data", 32'(regWriteData), 32'habcdef);
    frame(1'b1, 1'b1, 6'h05, 3'h0, 24'h000000);
    check("rd data", 32'(readData), 32'habcdef);
    check("writes", nWr, 32'h1);
    check("pin", 32'(link.lockdetSerialOutPin), 32'h1);
    check("lock", 32'(lockState), 32'h1);
    check("lock valid", 32'(lockValid), 32'h1);
    check("busy", 32'(busy), 32'h0);
    frame(1'b1, 1'b1, 6'h00, 3'h0, 24'h000000);
    check("rd id", 32'(readData), 32'(CHIP_ID));
    @(negedge clk);
    pllLock = 1'b0;
    frame(1'b1, 1'b1, 6'h05, 3'h0, 24'h000000);
    check("rd data", 32'(readData), 32'habcdef);
    check("lock", 32'(lockState), 32'h0);
    // A set lock level tells the idle pin apart from a final data bit of 0.
    pllLock = 1'b1;
    hard_reset();
    frame(1'b0, 1'b0, 6'h03, 3'h0, 24'h123456);
    check("proto", 32'(protocol), 32'(serial_port_pkg::PROTO_ADDR));
    check("writes", nWr, 32'h2);
    check("wr addr", 32'(regWriteAddr), 32'h03);
    check("wr data", 32'(regWriteData), 32'h123456);
    check("rd id", 32'(readData), 32'(CHIP_ID));
    for (int c = 1; c < 8; c++) begin
      frame(1'b0, 1'b0, 6'h04, 3'(c), 24'hffffff);
    end
    check("writes", nWr, 32'h2);
    frame(1'b0, 1'b0, 6'h00, 3'h0, 24'h000003);
    check("rd addr", 32'(regReadAddr), 32'h03);
    frame(1'b0, 1'b0, 6'h00, 3'h0, 24'h000003);
    check("rd addr", 32'(regReadAddr), 32'h03);
    check("rd data", 32'(readData), 32'h123456);
    check("pin", 32'(link.lockdetSerialOutPin), 32'h1);
    frame(1'b0, 1'b0, 6'h00, 3'h0, 24'h000020);
    check("soft", nSoft, 32'h1);
    check("proto", 32'(protocol), 32'(serial_port_pkg::PROTO_ADDR));
    complete_run();
  end

  // Fifteen frames of about 300 cycles each fit well inside this span.
  initial begin
    repeat (20000) @(posedge clk);
    nFail++;
    complete_run();
  end
endmodule : dual_protocol_serial_slave_port_tb
`default_nettype wire
